/* rtl/event_sync.v */
// Two-flip-flop synchroniser for a vector of asynchronous event levels.
`timescale 1ns/1ns
`default_nettype none

module event_sync #(
    parameter WIDTH = 7
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    // The first stage feeds the second stage only.
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
        end
    end

    assign dout = stage2_ff;

endmodule

`default_nettype wire

/* rtl/reset_cause_defines.vh */
// Constants shared by the reset-cause flag register block.
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

// Register byte addresses on the AXI4-Lite bus.
`define ADDR_FLAGS 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C
`define ADDR_WORD_MASK 8'hFC

// Register select codes returned by the address decoder.
`define SEL_NONE 3'h0
`define SEL_FLAGS 3'h1
`define SEL_CTRL 3'h2
`define SEL_IRQ_STATUS 3'h3
`define SEL_IRQ_MASK 3'h4

// Bit positions in reset_cause_flags.
`define BIT_STK_OVF 7
`define BIT_STK_UNF 6
`define BIT_WDT_N 4
`define BIT_PIN_N 3
`define BIT_INSTR_N 2
`define BIT_POR_N 1
`define BIT_BOR_N 0

// Implemented bits of reset_cause_flags; bit 5 is absent.
`define FLAGS_IMPL_MASK 8'hDF
// Power-on value of reset_cause_flags.
`define FLAGS_POR_VALUE 8'h1C

// Control register.
`define CTRL_STACK_RESET_EN 0
`define CTRL_RESET 1'h0

// Index of each reset source in the synchronised event vector.
`define EV_WDT 0
`define EV_PIN 1
`define EV_INSTR 2
`define EV_OVF 3
`define EV_UNF 4
`define EV_BOR 5
`define EV_LOW_POWER_BROWNOUT_DETECTOR 6
`define NUM_EVENTS 7

// Interrupt status and mask bits.
`define IRQ_WDT 0
`define IRQ_PIN 1
`define IRQ_INSTR 2
`define IRQ_OVF 3
`define IRQ_UNF 4
`define IRQ_BOR 5
`define IRQ_WIDTH 6
`define IRQ_RESET 6'h00

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/reset_cause_flag_register.v */
// Reset-cause flag register with AXI4-Lite access and a sticky interrupt.
//
// Notes on behaviour
// - Stack overflow sets bit 7; stays until firmware writes zero; power-on and brown-out clear it.
// - Stack underflow sets bit 6; stays until firmware writes zero; power-on and brown-out clear it.
// - Bit 5 does not exist: it reads zero and ignores writes.
// - Watchdog reset clears bit 4; firmware may rewrite one; power-on and brown-out give one.
// - External pin reset clears bit 3; firmware may rewrite one; power-on gives one.
// - Reset instruction clears bit 2; firmware may rewrite one; power-on gives one.
// - Power-on clears bit 1, other resets leave it; firmware rewrites one afterwards.
// - Brown-out clears bit 0; firmware rewrites one after power-on or brown-out.
// - Power-on and brown-out load one set of values, except that brown-out leaves bit 1; other resets another.
// - Stack flags are set by hardware, others cleared; all stay readable and writable.
// - Low-power and standard brown-out detectors both drive the brown-out flag.
// - Stack faults request a reset only when the stack fault enable is set.
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.vh"

module reset_cause_flag_register #(
    parameter ADDR_WIDTH = 8
) (
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address channel.
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel.
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel.
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel.
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Reset source levels, each from outside this clock domain.
    input wire watchdog_timeout,
    input wire external_reset_pin_event,
    input wire reset_instr_event,
    input wire stack_overflow_event,
    input wire stack_underflow_event,
    input wire brownout_detector,
    input wire low_power_brownout_detector,
    // Outputs.
    output wire stack_fault_reset_req,
    output wire [7:0] reset_cause_flags,
    output wire irq
);

    // Decodes a byte address into a register select code.
    function [2:0] decode_addr;
        input [ADDR_WIDTH-1:0] addr;
        reg [7:0] word;
        begin
            word = addr[7:0] & `ADDR_WORD_MASK;
            case (word)
                `ADDR_FLAGS: decode_addr = `SEL_FLAGS;
                `ADDR_CTRL: decode_addr = `SEL_CTRL;
                `ADDR_IRQ_STATUS: decode_addr = `SEL_IRQ_STATUS;
                `ADDR_IRQ_MASK: decode_addr = `SEL_IRQ_MASK;
                default: decode_addr = `SEL_NONE;
            endcase
            // A shift keeps this legal when the address is exactly one byte wide.
            if ((addr >> 8) != {ADDR_WIDTH{1'b0}}) begin
                decode_addr = `SEL_NONE;
            end
        end
    endfunction

    // Bus state.
    reg awready_ff;
    reg wready_ff;
    reg aw_full_ff;
    reg w_full_ff;
    reg [ADDR_WIDTH-1:0] awaddr_ff;
    reg [7:0] wdata_ff;
    reg wstrb0_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg arready_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [31:0] rdata_ff;

    // Block state.
    reg [7:0] flags_ff;
    reg [7:0] nxt_flags;
    reg ctrl_ff;
    reg [`IRQ_WIDTH-1:0] irq_status_ff;
    reg [`IRQ_WIDTH-1:0] nxt_irq_status;
    reg [`IRQ_WIDTH-1:0] irq_mask_ff;
    reg irq_ff;
    reg stack_req_ff;
    reg [`NUM_EVENTS-1:0] ev_prev_ff;

    wire [`NUM_EVENTS-1:0] ev_raw;
    wire [`NUM_EVENTS-1:0] ev_sync;
    wire [`NUM_EVENTS-1:0] ev_rise;
    wire bor_event;
    wire stack_event;
    wire do_write;
    wire [2:0] wr_sel;
    wire [2:0] rd_sel;
    wire wr_hit;
    wire wr_flags;
    wire wr_ctrl;
    wire wr_irq_status;
    wire wr_irq_mask;
    wire [`IRQ_WIDTH-1:0] irq_events;

    assign ev_raw[`EV_WDT] = watchdog_timeout;
    assign ev_raw[`EV_PIN] = external_reset_pin_event;
    assign ev_raw[`EV_INSTR] = reset_instr_event;
    assign ev_raw[`EV_OVF] = stack_overflow_event;
    assign ev_raw[`EV_UNF] = stack_underflow_event;
    assign ev_raw[`EV_BOR] = brownout_detector;
    assign ev_raw[`EV_LOW_POWER_BROWNOUT_DETECTOR] = low_power_brownout_detector;

    event_sync #(
        .WIDTH(`NUM_EVENTS)
    ) u_event_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(ev_raw),
        .dout(ev_sync)
    );

    // A source that stays asserted counts once, at its rising edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev_ff <= {`NUM_EVENTS{1'b0}};
        end else begin
            ev_prev_ff <= ev_sync;
        end
    end

    assign ev_rise = ev_sync & ~ev_prev_ff;
    assign bor_event = ev_rise[`EV_BOR] | ev_rise[`EV_LOW_POWER_BROWNOUT_DETECTOR];
    assign stack_event = ev_rise[`EV_OVF] | ev_rise[`EV_UNF];

    // Write path: address and data are taken in either order.
    assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
    assign wr_sel = decode_addr(awaddr_ff);
    assign wr_hit = do_write & wstrb0_ff;
    assign wr_flags = wr_hit & (wr_sel == `SEL_FLAGS);
    assign wr_ctrl = wr_hit & (wr_sel == `SEL_CTRL);
    assign wr_irq_status = wr_hit & (wr_sel == `SEL_IRQ_STATUS);
    assign wr_irq_mask = wr_hit & (wr_sel == `SEL_IRQ_MASK);
    assign rd_sel = decode_addr(s_axi_araddr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= {ADDR_WIDTH{1'b0}};
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `RESP_OKAY;
        end else begin
            // Ready opens the cycle after reset and after each response.
            if (!aw_full_ff && !bvalid_ff && !awready_ff) begin
                awready_ff <= 1'b1;
            end
            if (!w_full_ff && !bvalid_ff && !wready_ff) begin
                wready_ff <= 1'b1;
            end
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
                aw_full_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
                w_full_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (do_write) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                if (wr_sel == `SEL_NONE) begin
                    bresp_ff <= `RESP_SLVERR;
                end else begin
                    bresp_ff <= `RESP_OKAY;
                end
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read path: data are registered at the address handshake.
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= `RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else begin
            if (!rvalid_ff && !arready_ff) begin
                arready_ff <= 1'b1;
            end
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rresp_ff <= `RESP_OKAY;
                case (rd_sel)
                    `SEL_FLAGS: rdata_ff <= {24'h000000, flags_ff & `FLAGS_IMPL_MASK};
                    `SEL_CTRL: rdata_ff <= {31'h00000000, ctrl_ff};
                    `SEL_IRQ_STATUS: rdata_ff <= {26'h0000000, irq_status_ff};
                    `SEL_IRQ_MASK: rdata_ff <= {26'h0000000, irq_mask_ff};
                    default: begin
                        rdata_ff <= 32'h00000000;
                        rresp_ff <= `RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Flag update: firmware write first, hardware events override it.
    always @* begin
        nxt_flags = flags_ff;
        if (wr_flags) begin
            nxt_flags = wdata_ff & `FLAGS_IMPL_MASK;
        end
        if (ev_rise[`EV_OVF]) begin
            nxt_flags[`BIT_STK_OVF] = 1'b1;
        end
        if (ev_rise[`EV_UNF]) begin
            nxt_flags[`BIT_STK_UNF] = 1'b1;
        end
        if (ev_rise[`EV_WDT]) begin
            nxt_flags[`BIT_WDT_N] = 1'b0;
        end
        if (ev_rise[`EV_PIN]) begin
            nxt_flags[`BIT_PIN_N] = 1'b0;
        end
        if (ev_rise[`EV_INSTR]) begin
            nxt_flags[`BIT_INSTR_N] = 1'b0;
        end
        // Brown-out is a full device reset, so its values win over all.
        if (bor_event) begin
            nxt_flags[`BIT_STK_OVF] = 1'b0;
            nxt_flags[`BIT_STK_UNF] = 1'b0;
            nxt_flags[`BIT_WDT_N] = 1'b1;
            nxt_flags[`BIT_PIN_N] = 1'b1;
            nxt_flags[`BIT_INSTR_N] = 1'b1;
            nxt_flags[`BIT_BOR_N] = 1'b0;
        end
    end

    // The bus reset stands for the power-on reset of the flags.
    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= `FLAGS_POR_VALUE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // Control register and stack fault reset request.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `CTRL_RESET;
            stack_req_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= wdata_ff[`CTRL_STACK_RESET_EN];
            end
            stack_req_ff <= stack_event & ctrl_ff;
        end
    end

    // Interrupt: sticky status, write one to clear, a new event wins.
    assign irq_events[`IRQ_WDT] = ev_rise[`EV_WDT];
    assign irq_events[`IRQ_PIN] = ev_rise[`EV_PIN];
    assign irq_events[`IRQ_INSTR] = ev_rise[`EV_INSTR];
    assign irq_events[`IRQ_OVF] = ev_rise[`EV_OVF];
    assign irq_events[`IRQ_UNF] = ev_rise[`EV_UNF];
    assign irq_events[`IRQ_BOR] = bor_event;

    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_irq_status) begin
            nxt_irq_status = nxt_irq_status & ~wdata_ff[`IRQ_WIDTH-1:0];
        end
        nxt_irq_status = nxt_irq_status | irq_events;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_ff <= `IRQ_RESET;
            irq_mask_ff <= `IRQ_RESET;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            if (wr_irq_mask) begin
                irq_mask_ff <= wdata_ff[`IRQ_WIDTH-1:0];
            end
            // Registered so that the pin has no combinational path.
            irq_ff <= |(irq_status_ff & irq_mask_ff);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign stack_fault_reset_req = stack_req_ff;
    assign reset_cause_flags = flags_ff;
    assign irq = irq_ff;

endmodule

`default_nettype wire

/* verif/reset_cause_assertions.sv */
// Port assertions for the reset-cause flag register.
`timescale 1ns/1ns
`default_nettype none
module reset_cause_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire watchdog_timeout,
    input wire external_reset_pin_event,
    input wire reset_instr_event,
    input wire stack_overflow_event,
    input wire stack_underflow_event,
    input wire brownout_detector,
    input wire low_power_brownout_detector,
    input wire [7:0] reset_cause_flags
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence write_done;
        $rose(s_axi_bvalid);
    endsequence
    sequence brownout_seen;
        $rose(brownout_detector) or $rose(low_power_brownout_detector);
    endsequence
    // Events pass two sync flops and an edge detector, so allow a small window.
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    bit5_zero_a: assert property (reset_cause_flags[5] == 1'h0)
        else $error("absent bit reads one");
    ovf_set_a: assert property ($rose(stack_overflow_event) |-> ##[2:5] reset_cause_flags[7])
        else $error("overflow flag not set");
    unf_set_a: assert property ($rose(stack_underflow_event) |-> ##[2:5] reset_cause_flags[6])
        else $error("underflow flag not set");
    wdt_clear_a: assert property ($rose(watchdog_timeout) |-> ##[2:5] !reset_cause_flags[4])
        else $error("watchdog flag not cleared");
    pin_clear_a: assert property ($rose(external_reset_pin_event) |-> ##[2:5] !reset_cause_flags[3])
        else $error("pin flag not cleared");
    instr_clear_a: assert property ($rose(reset_instr_event) |-> ##[2:5] !reset_cause_flags[2])
        else $error("instruction flag not cleared");
    bor_clear_a: assert property (brownout_seen |-> ##[2:5] !reset_cause_flags[0])
        else $error("brown-out flag not cleared");
    por_kept_a: assert property ($changed(reset_cause_flags[1]) |-> write_done)
        else $error("power-on flag moved without a write");
endmodule
bind reset_cause_flag_register reset_cause_checker chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .watchdog_timeout(watchdog_timeout),
    .external_reset_pin_event(external_reset_pin_event), .reset_instr_event(reset_instr_event),
    .stack_overflow_event(stack_overflow_event), .stack_underflow_event(stack_underflow_event),
    .brownout_detector(brownout_detector), .low_power_brownout_detector(low_power_brownout_detector),
    .reset_cause_flags(reset_cause_flags));
`default_nettype wire

/* verif/test_reset_cause_flag_register.sv */
// Self-checking testbench for the reset-cause flag register.
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_defines.vh"
module test_reset_cause_flag_register;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, seed = 32'h802F6FD7;
    logic [3:0] wstrb = 4'hF;
    logic [6:0] ev_v = 7'h00;
    logic [7:0] exp_f;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int failures = 0, n_compared = 0, req_cnt = 0;
    wire awready, wready, bvalid, arready, rvalid, req, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] flags;
    reset_cause_flag_register DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watchdog_timeout(ev_v[`EV_WDT]), .external_reset_pin_event(ev_v[`EV_PIN]),
        .reset_instr_event(ev_v[`EV_INSTR]), .stack_overflow_event(ev_v[`EV_OVF]),
        .stack_underflow_event(ev_v[`EV_UNF]), .brownout_detector(ev_v[`EV_BOR]),
        .low_power_brownout_detector(ev_v[`EV_LOW_POWER_BROWNOUT_DETECTOR]), .stack_fault_reset_req(req),
        .reset_cause_flags(flags), .irq(irq));
    initial begin
        forever #4 aclk = ~aclk;
    end
    function automatic [31:0] xs(input [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Results are compared in arrival order against the notes the drivers queued.
    always @(posedge aclk) begin
        if (rvalid === 1'h1 && rready === 1'h1) check({rresp, rdata}, rq.pop_front());
        if (bvalid === 1'h1 && bready === 1'h1) check({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (req === 1'h1) req_cnt++;
    end
    task automatic rd(input [7:0] a, input [7:0] d, input [1:0] r);
        rq.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        rready <= 1'h1;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
        logic aw, w;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        aw = 1'h1;
        w = 1'h1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'h1) begin
                aw = 1'h0;
                awvalid <= 1'h0;
            end
            if (w && wready === 1'h1) begin
                w = 1'h0;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask
    task automatic fire(input int i);
        ev_v[i] <= 1'h1;
        repeat (2) @(posedge aclk);
        ev_v[i] <= 1'h0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic do_reset;
        aresetn <= 1'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask
    task automatic give_verdict;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(8 * 20000);
        failures++;
        give_verdict();
    end
    initial begin
        @(posedge aclk);
        do_reset();
        check({33'h0, irq}, 34'h0);
        rd(`ADDR_FLAGS, `FLAGS_POR_VALUE, `RESP_OKAY);
        wr(`ADDR_FLAGS, 32'hFFFFFF3F, `RESP_OKAY);
        exp_f = 8'h1F;
        rd(`ADDR_FLAGS, exp_f, `RESP_OKAY);
        // Indices 0..2 clear the active-low flags, 3..4 set the sticky stack flags.
        for (int k = 0; k < 5; k++) begin
            fire(k);
            exp_f = (k < 3) ? exp_f & ~(8'h10 >> k) : exp_f | (8'h80 >> (k - 3));
            rd(`ADDR_FLAGS, exp_f, `RESP_OKAY);
        end
        check(34'(req_cnt), 34'h0);
        wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
        rd(`ADDR_CTRL, 8'h01, `RESP_OKAY);
        fire(`EV_OVF);
        check(34'(req_cnt), 34'h1);
        rd(`ADDR_FLAGS, exp_f, `RESP_OKAY);
        wr(`ADDR_FLAGS, 32'h0, `RESP_OKAY);
        rd(`ADDR_FLAGS, 8'h00, `RESP_OKAY);
        wr(`ADDR_FLAGS, 32'hC2, `RESP_OKAY);
        fire(`EV_BOR);
        rd(`ADDR_FLAGS, 8'h1E, `RESP_OKAY);
        wr(`ADDR_FLAGS, 32'hC1, `RESP_OKAY);
        fire(`EV_LOW_POWER_BROWNOUT_DETECTOR);
        rd(`ADDR_FLAGS, 8'h1C, `RESP_OKAY);
        check({33'h0, irq}, 34'h0);
        rd(`ADDR_IRQ_STATUS, 8'h3F, `RESP_OKAY);
        wr(`ADDR_IRQ_STATUS, 32'h3F, `RESP_OKAY);
        wr(`ADDR_IRQ_MASK, 32'h02, `RESP_OKAY);
        rd(`ADDR_IRQ_STATUS, 8'h00, `RESP_OKAY);
        fire(`EV_WDT);
        check({33'h0, irq}, 34'h0);
        fire(`EV_PIN);
        check({33'h0, irq}, 34'h1);
        wr(`ADDR_IRQ_STATUS, 32'h02, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        check({33'h0, irq}, 34'h0);
        rd(8'h10, 8'h00, `RESP_SLVERR);
        wr(8'h10, 32'hFF, `RESP_SLVERR);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            wr(`ADDR_FLAGS, seed, `RESP_OKAY);
            rd(`ADDR_FLAGS, seed[7:0] & 8'hDF, `RESP_OKAY);
        end
        // The watchdog edge is timed to reach the flags in the cycle the write lands.
        ev_v[`EV_WDT] <= 1'h1;
        @(posedge aclk);
        wr(`ADDR_FLAGS, 32'hDF, `RESP_OKAY);
        ev_v[`EV_WDT] <= 1'h0;
        wstrb <= 4'h0;
        wr(`ADDR_FLAGS, 32'h00, `RESP_OKAY);
        wstrb <= 4'hF;
        rd(`ADDR_FLAGS, 8'hCF, `RESP_OKAY);
        do_reset();
        rd(`ADDR_FLAGS, `FLAGS_POR_VALUE, `RESP_OKAY);
        rd(`ADDR_IRQ_MASK, 8'h00, `RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
